/* File: rtl/phs_pkg.sv */
`default_nettype none
package phs_pkg;
  localparam int NCH = 4;
  localparam int SLOT_W = 7;
  localparam int BOFF_W = 3;
  localparam int CNT_W = 10;
  localparam int SYNC_STAGES = 3;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 19;
  // per channel register index (addr[2:0]); addr[4:3] picks the channel
  localparam logic [2:0] REG_TX_SLOT = 3'h0;
  localparam logic [2:0] REG_TX_BOFF = 3'h1;
  localparam logic [2:0] REG_RX_SLOT = 3'h2;
  localparam logic [2:0] REG_RX_BOFF = 3'h3;
  localparam logic [2:0] REG_PORT_SEL = 3'h4;
  localparam logic [2:0] REG_TX_DATA_HI = 3'h5;
  localparam logic [2:0] REG_TX_DATA_LO = 3'h6;
  localparam logic [2:0] REG_GLOBAL = 3'h7;
  // port select fields
  localparam int PSEL_TX_A = 0;
  localparam int PSEL_TX_B = 1;
  localparam int PSEL_RX_B = 2;
  // global fields
  localparam int GBL_TX_LIN = 0;
  localparam int GBL_RX_LIN = 1;
  localparam int GBL_SIG = 2;
  localparam int GBL_TX_RISE = 3;
  localparam int GBL_OVF = 4;
  // values after reset: slot n for channel n, zero offsets, port A, falling edge
  localparam logic [SLOT_W-1:0] SLOT_RST_STEP = 7'h01;
  localparam logic [BOFF_W-1:0] BOFF_RST = 3'h0;
  localparam logic [2:0] PSEL_RST = 3'h1;
  localparam logic [3:0] GBL_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;
endpackage
`default_nettype wire

/* File: rtl/phs_slot_interface.sv */
// Functional notes
// - linear transmit sends 16 bits over two slots starting at the programmed slot.
// - companded transmit puts one 8-bit sample in exactly one slot.
// - signaling on: slot after the companded byte carries signaling, forming 16 bits.
// - frame sync marks transmit slot 0; all transmit positions count from it.
// - time slot settings are 7 bits, up to 128 byte channels.
// - any PCLK rate from 128 kHz to 8.192 MHz works.
// - 3-bit clock slot delays a channel by 0 to 7 PCLK periods.
// - offset beyond remainder R: fractional tail carries junk with drive enable on.
// - transmit on port A, B or both, each with its active-low drive enable.
// - transmit outputs change on falling or rising PCLK edge, as programmed.
// - transmit bytes go most significant bit first.
// - host can read the transmit sample through the command port.
// - companded receive bytes go to the expander; linear words bypass it.
// - frame sync marks receive slot 0; all receive positions count from it.
// - each channel receives from port A or port B, as programmed.
// - frame sync is sampled on the falling PCLK edge.
// - reset: slots 0..3 for channels 0..3, offsets zero, falling-edge transmit.
// - linear samples are 16-bit two's complement, sign bit first.
`default_nettype none

module phs_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_in & in_ready_out;
  wire load = (cnt_q != '0) & (~out_valid_out | out_ready_in);

  assign in_ready_out = (cnt_q + (AW+1)'(out_valid_out)) < (AW+1)'(DEPTH); // output stage counts as a word

  // storage words carry no reset; pointers, count and output stage are the control state
  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // pointers and count; output stage is a register so the top sees flop outputs
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (ce_in) begin
      if (push) wr_q <= wr_q + 1'b1;
      if (load) begin
        rd_q <= rd_q + 1'b1;
        out_data_out <= mem_q[rd_q];
        out_valid_out <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule

module phs_slot_interface (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic PCLK_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic PCM_IN_PORT_A_IN,
  input wire logic PCM_IN_PORT_B_IN,
  output logic PCM_OUT_PORT_A_OUT,
  output logic PCM_OUT_PORT_A_OE_OUT,
  output logic PCM_OUT_PORT_B_OUT,
  output logic PCM_OUT_PORT_B_OE_OUT,
  output logic OUT_DRIVE_ENABLE_A_N_OUT,
  output logic OUT_DRIVE_ENABLE_B_N_OUT,
  input wire logic [16*phs_pkg::NCH-1:0] TX_SAMPLE_IN,
  input wire logic [8*phs_pkg::NCH-1:0] TX_SIGNAL_IN,
  output logic RX_VALID_OUT,
  input wire logic RX_READY_IN,
  output logic [15:0] RX_DATA_OUT,
  output logic [1:0] RX_CHANNEL_OUT,
  output logic RX_LINEAR_OUT,
  input wire logic CFG_WR_IN,
  input wire logic CFG_RD_IN,
  input wire logic [4:0] CFG_ADDR_IN,
  input wire logic [7:0] CFG_WDATA_IN,
  output logic [7:0] CFG_RDATA_OUT
);
  import phs_pkg::*;

  logic [SYNC_STAGES-1:0] sync_q [4];
  logic [3:0] filt_q;
  logic pclk_prev_q, fs_prev_q, frame_seen_q, ovf_q;
  logic [CNT_W-1:0] cnt_q;
  logic [SLOT_W-1:0] tx_slot_q [NCH];
  logic [SLOT_W-1:0] rx_slot_q [NCH];
  logic [BOFF_W-1:0] tx_boff_q [NCH];
  logic [BOFF_W-1:0] rx_boff_q [NCH];
  logic [2:0] psel_q [NCH];
  logic [15:0] tx_hold_q [NCH];
  logic [7:0] sig_hold_q [NCH];
  logic [15:0] rx_sh_q [NCH];
  logic [3:0] gbl_q;
  logic [15:0] tx_word [NCH];
  logic [CNT_W-1:0] tx_off [NCH];
  logic [CNT_W-1:0] rx_off [NCH];
  logic [NCH-1:0] tx_bit, act_a, act_b, rx_done;
  logic [15:0] rx_word [NCH];
  logic [FIFO_W-1:0] push_data;
  logic fifo_ready;
  logic [7:0] rd_mux;

  // pins from the highway: three flops, a change counts once stages two and three agree
  wire [3:0] pin_vec = {PCM_IN_PORT_B_IN, PCM_IN_PORT_A_IN, FRAME_SYNC_IN, PCLK_IN};
  for (genvar p = 0; p < 4; p++) begin : g_sync
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        sync_q[p] <= '0;
        filt_q[p] <= 1'b0;
      end else if (CE_IN) begin
        sync_q[p] <= {sync_q[p][SYNC_STAGES-2:0], pin_vec[p]};
        if (sync_q[p][1] == sync_q[p][2]) filt_q[p] <= sync_q[p][2];
      end
    end
  end

  // edge decode of the filtered bit clock
  wire pclk_rise = filt_q[0] & ~pclk_prev_q;
  wire pclk_fall = ~filt_q[0] & pclk_prev_q;
  wire frame_start = pclk_fall & filt_q[1] & ~fs_prev_q;
  wire tx_lin = gbl_q[GBL_TX_LIN];
  wire rx_lin = gbl_q[GBL_RX_LIN];
  wire sig_en = gbl_q[GBL_SIG] & ~tx_lin;
  wire tx_rise = gbl_q[GBL_TX_RISE];
  // counter saturates so a missing frame sync cannot wrap onto slot 0
  wire [CNT_W-1:0] nxt_cnt = frame_start ? '0 : (cnt_q == CNT_MAX ? cnt_q : cnt_q + 1'b1);
  wire tx_edge = tx_rise ? pclk_rise : pclk_fall;
  wire [CNT_W-1:0] tx_pos = tx_rise ? cnt_q : nxt_cnt;
  // two slots for linear or signaling, one slot otherwise
  wire [4:0] tx_len = (tx_lin | sig_en) ? LEN_WORD : LEN_BYTE;
  wire [4:0] rx_len = rx_lin ? LEN_WORD : LEN_BYTE;
  wire rx_take = pclk_fall & frame_seen_q & (frame_start | (cnt_q != CNT_MAX)); // parked count takes no bit twice
  wire [1:0] cfg_ch = CFG_ADDR_IN[4:3];
  wire [2:0] cfg_reg = CFG_ADDR_IN[2:0];

  // frame sync sets bit 0; count fits up to 1024 bits per frame
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pclk_prev_q <= 1'b0;
      fs_prev_q <= 1'b0;
      frame_seen_q <= 1'b0;
      cnt_q <= CNT_MAX;
    end else if (CE_IN) begin
      pclk_prev_q <= filt_q[0];
      if (pclk_fall) begin
        fs_prev_q <= filt_q[1];
        cnt_q <= nxt_cnt;
        if (frame_start) frame_seen_q <= 1'b1;
      end
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // start = offset + 8 * slot
    wire [CNT_W-1:0] tx_start = {tx_slot_q[i], 3'h0} + CNT_W'(tx_boff_q[i]);
    wire [CNT_W-1:0] rx_start = {rx_slot_q[i], 3'h0} + CNT_W'(rx_boff_q[i]);
    wire [15:0] smp_now = frame_start ? TX_SAMPLE_IN[16*i +: 16] : tx_hold_q[i];
    wire [7:0] sig_now = frame_start ? TX_SIGNAL_IN[8*i +: 8] : sig_hold_q[i];
    wire tx_in = tx_off[i] < CNT_W'(tx_len);
    wire rx_in = rx_off[i] < CNT_W'(rx_len);
    wire rx_pin = psel_q[i][PSEL_RX_B] ? filt_q[3] : filt_q[2];
    // linear word as is; data byte then signaling byte
    assign tx_word[i] = tx_lin ? smp_now : {smp_now[7:0], sig_en ? sig_now : 8'h00};
    assign tx_off[i] = tx_pos - tx_start;
    assign rx_off[i] = nxt_cnt - rx_start;
    assign tx_bit[i] = tx_word[i][4'(4'hF - tx_off[i][3:0])];
    // a window past the frame end stays driven until the next sync restarts the count
    assign act_a[i] = frame_seen_q & tx_in & psel_q[i][PSEL_TX_A];
    assign act_b[i] = frame_seen_q & tx_in & psel_q[i][PSEL_TX_B];
    assign rx_done[i] = rx_take & rx_in & (rx_off[i][3:0] == 4'(rx_len - 5'h01));
    assign rx_word[i] = rx_lin ? {rx_sh_q[i][14:0], rx_pin} : {8'h00, rx_sh_q[i][6:0], rx_pin};

    // slot n, zero offsets, port A after reset
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        tx_slot_q[i] <= SLOT_W'(i) * SLOT_RST_STEP;
        rx_slot_q[i] <= SLOT_W'(i) * SLOT_RST_STEP;
        tx_boff_q[i] <= BOFF_RST;
        rx_boff_q[i] <= BOFF_RST;
        psel_q[i] <= PSEL_RST;
      end else if (CE_IN && CFG_WR_IN && cfg_ch == 2'(i)) begin
        if (cfg_reg == REG_TX_SLOT) tx_slot_q[i] <= CFG_WDATA_IN[SLOT_W-1:0];
        if (cfg_reg == REG_TX_BOFF) tx_boff_q[i] <= CFG_WDATA_IN[BOFF_W-1:0];
        if (cfg_reg == REG_RX_SLOT) rx_slot_q[i] <= CFG_WDATA_IN[SLOT_W-1:0];
        if (cfg_reg == REG_RX_BOFF) rx_boff_q[i] <= CFG_WDATA_IN[BOFF_W-1:0];
        if (cfg_reg == REG_PORT_SEL) psel_q[i] <= CFG_WDATA_IN[2:0];
      end
    end

    // one snapshot per frame keeps a sample from tearing across its two slots
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        tx_hold_q[i] <= '0;
        sig_hold_q[i] <= '0;
        rx_sh_q[i] <= '0;
      end else if (CE_IN) begin
        if (frame_start) begin
          tx_hold_q[i] <= TX_SAMPLE_IN[16*i +: 16];
          sig_hold_q[i] <= TX_SIGNAL_IN[8*i +: 8];
        end
        if (rx_take && rx_in) rx_sh_q[i] <= {rx_sh_q[i][14:0], rx_pin};
      end
    end
  end

  // lowest finished channel wins; coinciding windows are a setup fault and raise overflow
  always_comb begin
    push_data = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (rx_done[k]) push_data = {2'(k), rx_lin, rx_word[k]};
    end
  end
  wire rx_push = |rx_done;
  wire rx_multi = (rx_done & (rx_done - 4'h1)) != 4'h0;
  wire ovf_set = rx_push & (~fifo_ready | rx_multi);

  // linear flag tells the inner side to bypass the expander
  phs_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(CLK_SYS_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CE_IN),
    .in_valid_in(rx_push),
    .in_ready_out(fifo_ready),
    .in_data_in(push_data),
    .out_valid_out(RX_VALID_OUT),
    .out_ready_in(RX_READY_IN),
    .out_data_out({RX_CHANNEL_OUT, RX_LINEAR_OUT, RX_DATA_OUT})
  );

  // global modes and overflow; a new overflow beats a clear in the same cycle
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      gbl_q <= GBL_RST;
      ovf_q <= 1'b0;
    end else if (CE_IN) begin
      if (CFG_WR_IN && cfg_reg == REG_GLOBAL) gbl_q <= CFG_WDATA_IN[3:0];
      if (ovf_set) ovf_q <= 1'b1;
      else if (CFG_WR_IN && cfg_reg == REG_GLOBAL && CFG_WDATA_IN[GBL_OVF]) ovf_q <= 1'b0;
    end
  end

  // or of all channels per port
  wire drv_a = |act_a;
  wire drv_b = |act_b;
  // outside slots data low with enable off, drive enables high
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PCM_OUT_PORT_A_OUT <= 1'b0;
      PCM_OUT_PORT_B_OUT <= 1'b0;
      PCM_OUT_PORT_A_OE_OUT <= 1'b0;
      PCM_OUT_PORT_B_OE_OUT <= 1'b0;
      OUT_DRIVE_ENABLE_A_N_OUT <= 1'b1;
      OUT_DRIVE_ENABLE_B_N_OUT <= 1'b1;
    end else if (CE_IN && tx_edge) begin
      PCM_OUT_PORT_A_OUT <= |(act_a & tx_bit);
      PCM_OUT_PORT_B_OUT <= |(act_b & tx_bit);
      PCM_OUT_PORT_A_OE_OUT <= drv_a;
      PCM_OUT_PORT_B_OE_OUT <= drv_b;
      OUT_DRIVE_ENABLE_A_N_OUT <= ~drv_a;
      OUT_DRIVE_ENABLE_B_N_OUT <= ~drv_b;
    end
  end

  // transmit sample readable; reads answer one cycle later
  always_comb begin
    case (cfg_reg)
      REG_TX_SLOT: rd_mux = {1'b0, tx_slot_q[cfg_ch]};
      REG_TX_BOFF: rd_mux = {5'h00, tx_boff_q[cfg_ch]};
      REG_RX_SLOT: rd_mux = {1'b0, rx_slot_q[cfg_ch]};
      REG_RX_BOFF: rd_mux = {5'h00, rx_boff_q[cfg_ch]};
      REG_PORT_SEL: rd_mux = {5'h00, psel_q[cfg_ch]};
      REG_TX_DATA_HI: rd_mux = tx_hold_q[cfg_ch][15:8];
      REG_TX_DATA_LO: rd_mux = tx_hold_q[cfg_ch][7:0];
      REG_GLOBAL: rd_mux = {2'h0, frame_seen_q, ovf_q, gbl_q};
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) CFG_RDATA_OUT <= 8'h00;
    else if (CE_IN && CFG_RD_IN) CFG_RDATA_OUT <= rd_mux;
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  chk_drive_pair_a: assert property (PCM_OUT_PORT_A_OE_OUT == !OUT_DRIVE_ENABLE_A_N_OUT)
    else $error("port A enable pair disagrees");
  chk_idle_float: assert property (!frame_seen_q |-> !PCM_OUT_PORT_A_OE_OUT && OUT_DRIVE_ENABLE_B_N_OUT)
    else $error("drive before first frame sync");
  chk_reset_slots: assert property ($rose(RSTN_IN) |-> tx_slot_q[3] == 7'h03 && rx_slot_q[2] == 7'h02)
    else $error("reset slot numbers wrong");
  chk_frame_zero: assert property (CE_IN && frame_start |=> cnt_q == '0)
    else $error("frame sync did not restart count");
  chk_sync_edge: assert property (frame_start |-> pclk_fall && $past(filt_q[0]))
    else $error("frame sync taken off a falling edge");
  chk_out_edge: assert property ($changed(PCM_OUT_PORT_B_OE_OUT) |-> $past(tx_edge))
    else $error("output moved off its edge");
  chk_msb_first: assert property (CE_IN && tx_edge && act_a == 4'h1 && tx_off[0] == '0
    |=> PCM_OUT_PORT_A_OUT == $past(tx_word[0][15]))
    else $error("first bit is not the msb");
  chk_rx_length: assert property (rx_done[0] |-> rx_off[0] == (rx_lin ? 10'h00F : 10'h007))
    else $error("receive word length wrong");
  chk_tx_window: assert property (CE_IN && tx_edge && act_b[1] && !act_b[0] && !act_b[2] && !act_b[3]
    |=> !OUT_DRIVE_ENABLE_B_N_OUT)
    else $error("port B not enabled in slot");
  cov_linear_rx: cover property (rx_done[0] && rx_lin);
  cov_sig_tx: cover property (sig_en && act_a[0] && tx_off[0] == 10'h008);
  cov_rise_mode: cover property (tx_rise && drv_b && tx_edge);
  cov_overflow: cover property (ovf_set);
endmodule
`default_nettype wire

/* File: verification/phs_highway_model.sv */
`default_nettype none
module phs_highway_model #(
  parameter int FRAME_BITS = 64,
  parameter int HALF_NS = 250
) (
  input wire logic run_in,
  input wire logic wire_a_in,
  input wire logic wire_b_in,
  input wire logic den_a_n_in,
  input wire logic den_b_n_in,
  output logic pclk_out,
  output logic fs_out,
  output logic din_a_out,
  output logic din_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [FRAME_BITS-1:0] rx_a, rx_b, tx_a, tx_b, dn_a, dn_b, txr_a;
  int cnt = 0;
  int prv;
  int frames = 0;
  initial begin
    pclk_out = 1'b0;
    fs_out = 1'b0;
    din_a_out = 1'b0;
    din_b_out = 1'b0;
  end
  // bit clock runs free; sync and data launched on the rise so they are settled at the fall
  always begin
    #HALF_NS;
    pclk_out = 1'b1;
    prv = (cnt + FRAME_BITS - 1) % FRAME_BITS;
    txr_a[prv] = wire_a_in; // pin just before a rising-edge update
    fs_out = run_in && (cnt == 0);
    din_a_out = rx_a[cnt]; // frame is whole bytes, so no last-slot exclusion is needed
    din_b_out = rx_b[cnt];
    #HALF_NS;
    pclk_out = 1'b0;
    // the pin at fall n still shows bit n-1 in both edge modes
    tx_a[prv] = wire_a_in;
    tx_b[prv] = wire_b_in;
    dn_a[prv] = den_a_n_in;
    dn_b[prv] = den_b_n_in;
    if (cnt == 0) frames++;
    cnt = (cnt + 1) % FRAME_BITS;
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`default_nettype none
module testbench;
  import phs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [6:0] ts; logic [2:0] bo; logic [2:0] psel; logic [3:0] gbl; logic [15:0] smp;
    logic [15:0] ew; logic [4:0] el; logic [6:0] rs; logic [2:0] rbo;
  } phs_row_t;
  // slot, offset, port sel, global, sample, expected tx word and length, rx slot and offset
  phs_row_t rows [6] = '{
    '{7'h00, 3'h0, 3'h1, 4'h0, 16'h12B4, 16'h00B4, 5'h08, 7'h02, 3'h0},
    '{7'h03, 3'h5, 3'h6, 4'h0, 16'h0081, 16'h0081, 5'h08, 7'h01, 3'h7},
    '{7'h05, 3'h7, 3'h3, 4'h3, 16'h8E71, 16'h8E71, 5'h10, 7'h04, 3'h3},
    '{7'h02, 3'h1, 3'h1, 4'h4, 16'h1247, 16'h473C, 5'h10, 7'h00, 3'h0},
    '{7'h01, 3'h2, 3'h1, 4'h8, 16'h00D2, 16'h00D2, 5'h08, 7'h06, 3'h5},
    '{7'h06, 3'h0, 3'h5, 4'h5, 16'h7F01, 16'h7F01, 5'h10, 7'h07, 3'h0}};
  logic clk = 1'b0, rstn = 1'b0, run = 1'b0, rx_ready = 1'b1, wr = 1'b0, rd = 1'b0, ce = 1'b1;
  logic pclk, fs, din_a, din_b, d_a, oe_a, d_b, oe_b, dn_a, dn_b, rx_valid, rx_lin, last_lin;
  logic [15:0] rx_data, last_word, ew;
  logic [1:0] rx_ch;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00, rdata, got;
  logic [63:0] tx_sample = 64'h0, ea, eb, rxp;
  logic [31:0] tx_signal = 32'h0000_003C, ch_hist = 32'h0;
  wire wire_a, wire_b;
  int num_errors = 0, tests_run = 0, pops = 0, p0, s, rl;
  assign wire_a = oe_a ? d_a : 1'bz;
  assign wire_b = oe_b ? d_b : 1'bz;
  always #12.5 clk = ~clk;
  phs_slot_interface phs_slot_interface_i (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .PCLK_IN(pclk),
    .FRAME_SYNC_IN(fs), .PCM_IN_PORT_A_IN(din_a), .PCM_IN_PORT_B_IN(din_b), .PCM_OUT_PORT_A_OUT(d_a),
    .PCM_OUT_PORT_A_OE_OUT(oe_a), .PCM_OUT_PORT_B_OUT(d_b), .PCM_OUT_PORT_B_OE_OUT(oe_b),
    .OUT_DRIVE_ENABLE_A_N_OUT(dn_a), .OUT_DRIVE_ENABLE_B_N_OUT(dn_b), .TX_SAMPLE_IN(tx_sample),
    .TX_SIGNAL_IN(tx_signal), .RX_VALID_OUT(rx_valid), .RX_READY_IN(rx_ready), .RX_DATA_OUT(rx_data),
    .RX_CHANNEL_OUT(rx_ch), .RX_LINEAR_OUT(rx_lin), .CFG_WR_IN(wr), .CFG_RD_IN(rd), .CFG_ADDR_IN(addr),
    .CFG_WDATA_IN(wdata), .CFG_RDATA_OUT(rdata));
  phs_highway_model phs_highway_model_i (.run_in(run), .wire_a_in(wire_a), .wire_b_in(wire_b),
    .den_a_n_in(dn_a), .den_b_n_in(dn_b), .pclk_out(pclk), .fs_out(fs), .din_a_out(din_a), .din_b_out(din_b));
  // consumer side of the receive buffer; keeps the last channel 0 word
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      pops <= pops + 1;
      ch_hist <= {ch_hist[29:0], rx_ch};
      if (rx_ch === 2'h0) begin
        last_word <= rx_data;
        last_lin <= rx_lin;
      end
    end
  end
  function automatic logic [63:0] line(int s, int n, logic [15:0] w, logic on, logic data);
    for (int b = 0; b < 64; b++) begin
      line[b] = (on && b >= s && b < s + n) ? (data ? w[s+n-1-b] : 1'b0) : (data ? 1'bz : 1'b1);
    end
  endfunction
  task automatic fail(input logic [63:0] g, input logic [63:0] e, input string what);
    num_errors++;
    $display("ERROR t=%0t %s got %h exp %h", $time, what, g, e);
  endtask
  task automatic cmp64(input logic [63:0] g, input logic [63:0] e, input string what);
    tests_run++;
    if (g !== e) fail(g, e, what);
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e, input string what);
    tests_run++;
    if (g !== e) fail({48'h0, g}, {48'h0, e}, what);
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string what);
    tests_run++;
    if (g !== e) fail({56'h0, g}, {56'h0, e}, what);
  endtask
  task automatic cfg_wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic cfg_rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask
  task automatic summarize();
    $display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_frames(input int n);
    int f0 = phs_highway_model_i.frames;
    for (int i = 0; i < n * 3000 && phs_highway_model_i.frames < f0 + n; i++) @(posedge clk);
    if (phs_highway_model_i.frames < f0 + n) begin
      fail(64'h0, 64'h1, "frame wait");
      summarize();
    end
  endtask
  initial begin
    phs_highway_model_i.rx_a = 64'hC3A5_96F0_3E71_5AD2;
    phs_highway_model_i.rx_b = 64'h1B8E_64D7_A259_F30C;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    run = 1'b1;
    // channels 1..3 silent and their receive slots beyond the frame
    for (int c = 1; c < 4; c++) begin
      cfg_wr({c[1:0], REG_PORT_SEL}, 8'h00);
      cfg_wr({c[1:0], REG_RX_SLOT}, 8'h7F);
    end
    foreach (rows[i]) begin
      cfg_wr({2'h0, REG_TX_SLOT}, {1'b0, rows[i].ts});
      cfg_wr({2'h0, REG_TX_BOFF}, {5'h00, rows[i].bo});
      cfg_wr({2'h0, REG_RX_SLOT}, {1'b0, rows[i].rs});
      cfg_wr({2'h0, REG_RX_BOFF}, {5'h00, rows[i].rbo});
      cfg_wr({2'h0, REG_PORT_SEL}, {5'h00, rows[i].psel});
      cfg_wr({2'h0, REG_GLOBAL}, {4'h0, rows[i].gbl});
      tx_sample = {48'h0, rows[i].smp};
      wait_frames(2);
      s = 8 * rows[i].ts + rows[i].bo;
      ew = rows[i].ew;
      ea = line(s, rows[i].el, ew, rows[i].psel[PSEL_TX_A], 1'b1);
      eb = line(s, rows[i].el, ew, rows[i].psel[PSEL_TX_B], 1'b1);
      cmp64(phs_highway_model_i.tx_a, ea, "port a bits");
      cmp64(phs_highway_model_i.tx_b, eb, "port b bits");
      cmp64(phs_highway_model_i.dn_a, line(s, rows[i].el, ew, rows[i].psel[PSEL_TX_A], 1'b0), "en a");
      cmp64(phs_highway_model_i.dn_b, line(s, rows[i].el, ew, rows[i].psel[PSEL_TX_B], 1'b0), "en b");
      if (rows[i].gbl[GBL_TX_RISE]) ea = {ea[62:0], ea[63]};
      cmp64(phs_highway_model_i.txr_a, ea, "edge choice");
      rxp = rows[i].psel[PSEL_RX_B] ? phs_highway_model_i.rx_b : phs_highway_model_i.rx_a;
      rl = rows[i].gbl[GBL_RX_LIN] ? 16 : 8;
      ew = 16'h0;
      for (int k = 0; k < rl; k++) ew[rl-1-k] = rxp[8*rows[i].rs+rows[i].rbo+k];
      cmp16(last_word, ew, "rx word");
      cmp16({15'h0, last_lin}, {15'h0, rows[i].gbl[GBL_RX_LIN]}, "rx linear");
      cfg_rd({2'h0, REG_TX_DATA_HI}, got);
      cmp8(got, rows[i].smp[15:8], "tx data hi");
      cfg_rd({2'h0, REG_TX_DATA_LO}, got);
      cmp8(got, rows[i].smp[7:0], "tx data lo");
      $display("row %0d done", i);
    end
    // setting widths: upper bits of slot and offset fields do not exist
    for (int r = 0; r < 4; r++) begin
      cfg_wr({2'h2, r[2:0]}, 8'hFF);
      cfg_rd({2'h2, r[2:0]}, got);
      cmp8(got, r[0] ? 8'h07 : 8'h7F, "field width");
    end
    $display("width test done");
    // a write while the clock enable is low must not land
    @(negedge clk);
    ce = 1'b0;
    cfg_wr({2'h0, REG_TX_SLOT}, 8'h55);
    ce = 1'b1;
    cfg_rd({2'h0, REG_TX_SLOT}, got);
    cmp8(got, {1'b0, rows[5].ts}, "frozen write");
    $display("enable test done");
    // second reset in mid-run with the highway quiet
    run = 1'b0;
    wait_frames(1);
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    cmp8({3'h0, oe_a, oe_b, dn_a, dn_b, rx_valid}, 8'h06, "outputs in reset");
    rstn = 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 5; r++) begin
        cfg_rd({c[1:0], r[2:0]}, got);
        cmp8(got, (r == 0 || r == 2) ? c[7:0] : (r == 4 ? 8'h01 : 8'h00), "reset value");
      end
    end
    cfg_rd({2'h0, REG_GLOBAL}, got);
    cmp8(got, 8'h00, "global after reset");
    $display("reset test done");
    // buffer fills with four words a frame while the consumer stalls
    rx_ready = 1'b0;
    run = 1'b1;
    wait_frames(6);
    cfg_rd({2'h0, REG_GLOBAL}, got);
    cmp8(got, 8'h30, "overflow and sync seen");
    run = 1'b0;
    wait_frames(1);
    p0 = pops;
    @(negedge clk);
    rx_ready = 1'b1;
    for (int i = 0; i < 200 && rx_valid !== 1'b0; i++) @(negedge clk);
    if (rx_valid !== 1'b0) fail(64'h0, 64'h1, "drain wait");
    cmp16(16'(pops - p0), 16'(FIFO_DEPTH), "drained words");
    // four whole frames were kept, so channels come out 0,1,2,3 four times
    cmp64({32'h0, ch_hist}, 64'h0000_0000_1B1B_1B1B, "rx channels");
    cfg_wr({2'h0, REG_GLOBAL}, 8'h10);
    cfg_rd({2'h0, REG_GLOBAL}, got);
    cmp8(got, 8'h20, "overflow cleared");
    $display("buffer test done");
    summarize();
  end
endmodule
`default_nettype wire
